//--- scm_pkg.sv
package scm_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PLL_CTRL_ONE = 16'h1c20;
  localparam logic [15:0] IDX_PLL_CTRL_TWO = 16'h1c21;
  localparam logic [15:0] IDX_PLL_CTRL_THREE = 16'h1c22;
  localparam logic [15:0] IDX_PLL_CTRL_FOUR = 16'h1c23;
  localparam logic [15:0] IDX_CLK_CFG_TWO = 16'h1c1f;
  localparam logic [15:0] ADR_PLL_CTRL_ONE = 16'(IDX_PLL_CTRL_ONE * 4);
  localparam logic [15:0] ADR_PLL_CTRL_TWO = 16'(IDX_PLL_CTRL_TWO * 4);
  localparam logic [15:0] ADR_PLL_CTRL_THREE = 16'(IDX_PLL_CTRL_THREE * 4);
  localparam logic [15:0] ADR_PLL_CTRL_FOUR = 16'(IDX_PLL_CTRL_FOUR * 4);
  localparam logic [15:0] ADR_CLK_CFG_TWO = 16'(IDX_CLK_CFG_TWO * 4);

  // ----------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------
  localparam int COUNTER_CLEAR_BIT = 15;
  localparam int POWER_DOWN_BIT = 12;
  localparam int MULT_MSB = 11;
  localparam int REF_BYPASS_BIT = 15;
  localparam int REF_RATIO_MSB = 11;
  localparam int OUT_DIV_EN_BIT = 9;
  localparam int OUT_RATIO_MSB = 7;
  localparam int SRC_SELECT_BIT = 0;
  localparam int PIN_STATE_BIT = 3;
  localparam logic [15:0] MASK_PLL_CTRL_TWO = 16'h8fff;
  localparam logic [15:0] MASK_PLL_CTRL_FOUR = 16'h02ff;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PLL_CTRL_ONE = 16'h1000;
  localparam logic [15:0] RST_PLL_CTRL_TWO = 16'h0000;
  localparam logic [15:0] RST_PLL_CTRL_THREE = 16'h0000;
  localparam logic [15:0] RST_PLL_CTRL_FOUR = 16'h0000;
  localparam logic RST_SRC_SELECT = 1'b0;

  // ----------------------------------------------------------------
  // Ratio offsets and timing
  // ----------------------------------------------------------------
  localparam logic [12:0] REF_DIV_OFFSET = 13'h0004;
  localparam logic [12:0] MULT_OFFSET = 13'h0004;
  localparam logic [12:0] OUT_DIV_OFFSET = 13'h0001;
  localparam int CLOCK_HZ = 25000000;
  localparam int LOCK_TIME_MS = 4;
  localparam longint LOCK_CYCLES = longint'(CLOCK_HZ) * LOCK_TIME_MS / 1000;

  // ----------------------------------------------------------------
  // Bus carriers and mode states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] datW;
  } scm_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] datR;
  } scm_wb_rsp_t;

  typedef enum logic [1:0] {
    MUX_BYPASS,
    MUX_PARK,
    MUX_PLL
  } scm_mux_state_t;

endpackage : scm_pkg

//--- scm_clock_mode_ctrl.sv
// Summary of operation
// (R1) Source select 1 takes system clock from PLL, 0 from bypass.
// (R2) Bypass uses RTC oscillator when select pin low, else external clock.
// (R3) Sampled select pin level is readable as a read-only status bit.
// (R4) PLL mode divides and multiplies the reference, output phase-locked.
// (R5) Software waits 4 ms in bypass before selecting PLL; no lock flag.
// (R6) Software enters bypass before changing any multiplier or divider.
// (R7) Switching between bypass and PLL produces no system clock glitch.
// (R8) Power-down bit powers down the PLL; usable in bypass mode.
// (R9) Reference bypass bit picks undivided or divided reference clock.
// (R10) Output divider enable routes PLL output through output divider.
// (R11) Multiplication factor is multiplier field plus 4.
// (R12) Software keeps PLL output within 60 to 120 MHz.
// (R13) Software keeps PLL input within 32.0 to 170 kHz.
// (R14) With RTC oscillator, software sets reference bypass to 1.
// (R15) Reprogram order: bypass, clear counter, ratios, then init 0806h.
// (R16) Then release power-down, set counter clear, wait 4 ms, select PLL.
// (R17) Software should stop peripherals except CPU and USB first.
// (R18) Reset selects bypass mode, source select 0.
// (R19) Reset holds power-down at 1; PLL gives no output clock.
// (R20) Reference divider divides by ratio field plus 4.
//
// The Wishbone slave port and the register offsets were decided locally.
module scm_clock_mode_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input scm_pkg::scm_wb_req_t wbReq,
  output scm_pkg::scm_wb_rsp_t wbRsp,
  // Clock sources, sampled levels
  input wire logic inputSelectPin,
  input wire logic rtcClock,
  input wire logic externalClockInput,
  input wire logic pllCoreClock,
  // Generated clocks
  output logic systemClock,
  output logic pllInputClock,
  output logic pllOutputClock,
  // Analog PLL controls
  output logic pllPowerDown,
  output logic pllCounterClear,
  output logic [12:0] pllMultiplier,
  output logic [15:0] pllInitWord
);

  // ----------------------------------------------------------------
  // Register file and bus slave
  // ----------------------------------------------------------------
  logic [15:0] ctrlOne, next_ctrlOne;
  logic [15:0] ctrlTwo, next_ctrlTwo;
  logic [15:0] ctrlThree, next_ctrlThree;
  logic [15:0] ctrlFour, next_ctrlFour;
  logic srcSelect, next_srcSelect;
  logic pinState, next_pinState;
  scm_pkg::scm_wb_rsp_t next_wbRsp;
  logic [12:0] next_pllMultiplier;
  logic access;
  logic wrTake;
  logic [15:0] wrMask;

  always_comb begin
    access = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
    wrTake = wbReq.cyc & wbReq.stb & wbReq.we & wbRsp.ack;
    wrMask = {{8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
    next_ctrlOne = ctrlOne;
    next_ctrlTwo = ctrlTwo;
    next_ctrlThree = ctrlThree;
    next_ctrlFour = ctrlFour;
    next_srcSelect = srcSelect;
    // (R3) Pin level sampled
    next_pinState = inputSelectPin;
    next_wbRsp.ack = access;
    next_wbRsp.datR = 32'h0000_0000;
    // Write lands on the acknowledged edge
    if (wrTake) begin
      case (wbReq.adr)
        scm_pkg::ADR_PLL_CTRL_ONE: begin
          next_ctrlOne = (ctrlOne & ~wrMask) | (wbReq.datW[15:0] & wrMask);
        end
        scm_pkg::ADR_PLL_CTRL_TWO: begin
          next_ctrlTwo = ((ctrlTwo & ~wrMask) | (wbReq.datW[15:0] & wrMask))
            & scm_pkg::MASK_PLL_CTRL_TWO;
        end
        scm_pkg::ADR_PLL_CTRL_THREE: begin
          next_ctrlThree = (ctrlThree & ~wrMask)
            | (wbReq.datW[15:0] & wrMask);
        end
        scm_pkg::ADR_PLL_CTRL_FOUR: begin
          next_ctrlFour = ((ctrlFour & ~wrMask)
            | (wbReq.datW[15:0] & wrMask)) & scm_pkg::MASK_PLL_CTRL_FOUR;
        end
        scm_pkg::ADR_CLK_CFG_TWO: begin
          // (R1) Software mode select
          if (wbReq.sel[0]) begin
            next_srcSelect = wbReq.datW[scm_pkg::SRC_SELECT_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (access && !wbReq.we) begin
      case (wbReq.adr)
        scm_pkg::ADR_PLL_CTRL_ONE: next_wbRsp.datR = {16'h0000, ctrlOne};
        scm_pkg::ADR_PLL_CTRL_TWO: next_wbRsp.datR = {16'h0000, ctrlTwo};
        scm_pkg::ADR_PLL_CTRL_THREE: next_wbRsp.datR = {16'h0000, ctrlThree};
        scm_pkg::ADR_PLL_CTRL_FOUR: next_wbRsp.datR = {16'h0000, ctrlFour};
        scm_pkg::ADR_CLK_CFG_TWO: begin
          // (R3) Pin state readback
          next_wbRsp.datR[scm_pkg::PIN_STATE_BIT] = pinState;
          next_wbRsp.datR[scm_pkg::SRC_SELECT_BIT] = srcSelect;
        end
        default: next_wbRsp.datR = 32'h0000_0000;
      endcase
    end
    // (R11) Factor is field plus 4
    next_pllMultiplier = {1'b0, ctrlOne[scm_pkg::MULT_MSB:0]}
      + scm_pkg::MULT_OFFSET;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // (R19) Power-down set at reset
      ctrlOne <= scm_pkg::RST_PLL_CTRL_ONE;
      ctrlTwo <= scm_pkg::RST_PLL_CTRL_TWO;
      ctrlThree <= scm_pkg::RST_PLL_CTRL_THREE;
      ctrlFour <= scm_pkg::RST_PLL_CTRL_FOUR;
      // (R18) Bypass after reset
      srcSelect <= scm_pkg::RST_SRC_SELECT;
      pinState <= 1'b0;
      wbRsp <= '0;
      pllMultiplier <= 13'h0000;
      pllPowerDown <= 1'b1;
      pllCounterClear <= 1'b0;
      pllInitWord <= 16'h0000;
    end else begin
      ctrlOne <= next_ctrlOne;
      ctrlTwo <= next_ctrlTwo;
      ctrlThree <= next_ctrlThree;
      ctrlFour <= next_ctrlFour;
      srcSelect <= next_srcSelect;
      pinState <= next_pinState;
      wbRsp <= next_wbRsp;
      pllMultiplier <= next_pllMultiplier;
      // (R8) Power-down drives PLL
      pllPowerDown <= ctrlOne[scm_pkg::POWER_DOWN_BIT];
      pllCounterClear <= ctrlOne[scm_pkg::COUNTER_CLEAR_BIT];
      pllInitWord <= ctrlThree;
    end
  end

  // ----------------------------------------------------------------
  // Reference and output dividers
  // ----------------------------------------------------------------
  logic bypassSource;
  logic pllRun;
  logic [1:0] divIn;
  logic [1:0] divBypass;
  logic [12:0] divRatio [2];
  logic [1:0] divOut;

  always_comb begin
    // (R2) Bypass source from pin state
    bypassSource = pinState ? externalClockInput : rtcClock;
    // (R19) No PLL clocks while powered down
    pllRun = ~ctrlOne[scm_pkg::POWER_DOWN_BIT]
      & ctrlOne[scm_pkg::COUNTER_CLEAR_BIT];
    divIn = {pllCoreClock, bypassSource};
    // (R9) Reference divider bypass
    divBypass[0] = ctrlTwo[scm_pkg::REF_BYPASS_BIT];
    // (R20) Reference ratio plus 4
    divRatio[0] = {1'b0, ctrlTwo[scm_pkg::REF_RATIO_MSB:0]}
      + scm_pkg::REF_DIV_OFFSET;
    // (R10) Output divider enable
    divBypass[1] = ~ctrlFour[scm_pkg::OUT_DIV_EN_BIT];
    divRatio[1] = {5'h00, ctrlFour[scm_pkg::OUT_RATIO_MSB:0]}
      + scm_pkg::OUT_DIV_OFFSET;
  end

  for (genvar i = 0; i < 2; i++) begin : gDiv
    logic prevIn, next_prevIn;
    logic [12:0] cnt, next_cnt;
    logic next_out;
    logic outQ;
    logic [12:0] cntPlus;

    assign divOut[i] = outQ;

    // (R4) Divide the PLL clocks
    always_comb begin
      cntPlus = cnt + 13'h0001;
      next_prevIn = divIn[i];
      next_cnt = cnt;
      if (!pllRun) begin
        next_cnt = 13'h0000;
      end else if (divIn[i] && !prevIn) begin
        next_cnt = (cntPlus >= divRatio[i]) ? 13'h0000 : cntPlus;
      end
      if (!pllRun) begin
        next_out = 1'b0;
      end else if (divBypass[i]) begin
        next_out = divIn[i];
      end else begin
        next_out = next_cnt < (divRatio[i] >> 1);
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        prevIn <= 1'b0;
        cnt <= 13'h0000;
        outQ <= 1'b0;
      end else begin
        prevIn <= next_prevIn;
        cnt <= next_cnt;
        outQ <= next_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Glitch-free system clock switch
  // ----------------------------------------------------------------
  scm_pkg::scm_mux_state_t muxState, next_muxState;
  logic next_systemClock;
  logic pllSource;

  always_comb begin
    pllSource = divOut[1];
    next_muxState = muxState;
    next_systemClock = 1'b0;
    // (R7) Leave the old source while it is low, join the new one while it is low
    case (muxState)
      scm_pkg::MUX_BYPASS: begin
        next_systemClock = bypassSource;
        if (srcSelect && !bypassSource) begin
          next_muxState = scm_pkg::MUX_PARK;
          next_systemClock = 1'b0;
        end
      end
      scm_pkg::MUX_PARK: begin
        // (R1) Join the selected source
        if (srcSelect && !pllSource) begin
          next_muxState = scm_pkg::MUX_PLL;
        end else if (!srcSelect && !bypassSource) begin
          next_muxState = scm_pkg::MUX_BYPASS;
        end
      end
      scm_pkg::MUX_PLL: begin
        next_systemClock = pllSource;
        if (!srcSelect && !pllSource) begin
          next_muxState = scm_pkg::MUX_PARK;
          next_systemClock = 1'b0;
        end
      end
      default: begin
        next_muxState = scm_pkg::MUX_BYPASS;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // (R18) Start in bypass
      muxState <= scm_pkg::MUX_BYPASS;
      systemClock <= 1'b0;
      pllInputClock <= 1'b0;
      pllOutputClock <= 1'b0;
    end else begin
      muxState <= next_muxState;
      systemClock <= next_systemClock;
      pllInputClock <= divOut[0];
      pllOutputClock <= divOut[1];
    end
  end

endmodule : scm_clock_mode_ctrl

//--- scm_mode_properties.sv
module scm_mode_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input scm_pkg::scm_wb_req_t wbReq,
  input scm_pkg::scm_wb_rsp_t wbRsp,
  // Clock sources
  input wire logic inputSelectPin,
  input wire logic rtcClock,
  input wire logic externalClockInput,
  input wire logic pllCoreClock,
  // Watched outputs
  input wire logic systemClock,
  input wire logic pllInputClock,
  input wire logic pllOutputClock,
  input wire logic pllPowerDown,
  input wire logic pllCounterClear,
  input wire logic [12:0] pllMultiplier,
  input wire logic [15:0] pllInitWord
);
  logic wrAck, ctlOne, running, bypSrc, settled;
  logic pinSeen, ctlThree;
  logic srcSel, refByp, outEn, next_srcSel, next_refByp, next_outEn;
  logic [5:0] quiet, next_quiet;
  assign wrAck = wbRsp.ack && wbReq.cyc && wbReq.stb && wbReq.we
    && wbReq.sel == 4'h3;
  assign ctlOne = wrAck && wbReq.adr == scm_pkg::ADR_PLL_CTRL_ONE;
  assign ctlThree = wrAck && wbReq.adr == scm_pkg::ADR_PLL_CTRL_THREE;
  assign running = !pllPowerDown && pllCounterClear;
  // Pin level as the block registers it
  assign bypSrc = pinSeen ? externalClockInput : rtcClock;
  assign settled = quiet > 6'h28;
  // Shadow of the mode bits
  always_comb begin
    next_srcSel = srcSel;
    next_refByp = refByp;
    next_outEn = outEn;
    next_quiet = (quiet == 6'h3f) ? quiet : quiet + 6'h01;
    if (wrAck) next_quiet = 6'h00;
    if (wrAck && wbReq.adr == scm_pkg::ADR_CLK_CFG_TWO) begin
      next_srcSel = wbReq.datW[0];
    end
    if (wrAck && wbReq.adr == scm_pkg::ADR_PLL_CTRL_TWO) begin
      next_refByp = wbReq.datW[15];
    end
    if (wrAck && wbReq.adr == scm_pkg::ADR_PLL_CTRL_FOUR) begin
      next_outEn = wbReq.datW[9];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pinSeen, srcSel, refByp, outEn, quiet} <= 10'h000;
    end else begin
      {pinSeen, srcSel, refByp, outEn, quiet} <=
        {inputSelectPin, next_srcSel, next_refByp, next_outEn, next_quiet};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  bypass_follow_a: assert property (
    settled && !srcSel |-> systemClock == $past(bypSrc))
    else $error("System clock not following bypass source");
  pll_follow_a: assert property (
    settled && srcSel |-> (systemClock == pllOutputClock)
      || (systemClock == $past(pllOutputClock)))
    else $error("System clock not following PLL output");
  no_glitch_a: assert property (
    systemClock |-> $past(bypSrc) || pllOutputClock)
    else $error("System clock high without a source high");
  power_ctl_a: assert property (
    ctlOne |-> ##2 pllPowerDown == $past(wbReq.datW[12], 2)
      && pllCounterClear == $past(wbReq.datW[15], 2))
    else $error("Power down or counter clear not taken");
  mult_offset_a: assert property (
    ctlOne |-> ##2
      pllMultiplier == 13'($past(wbReq.datW[11:0], 2)) + 13'h0004)
    else $error("Multiplier not field plus four");
  init_copy_a: assert property (
    ctlThree |-> ##2 pllInitWord == $past(wbReq.datW[15:0], 2))
    else $error("Init word not copied");
  down_silent_a: assert property (
    pllPowerDown && $past(pllPowerDown) && $past(pllPowerDown, 2)
      |-> !pllOutputClock)
    else $error("PLL output active while powered down");
  ref_bypass_a: assert property (
    settled && refByp && running |-> pllInputClock == $past(bypSrc, 2))
    else $error("Undivided reference not passed");
  out_bypass_a: assert property (
    settled && !outEn && running
      |-> pllOutputClock == $past(pllCoreClock, 2))
    else $error("Output divider not bypassed");
endmodule : scm_mode_properties

bind scm_clock_mode_ctrl scm_mode_properties chk (.mclk(mclk),
  .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
  .inputSelectPin(inputSelectPin), .rtcClock(rtcClock),
  .externalClockInput(externalClockInput), .pllCoreClock(pllCoreClock),
  .systemClock(systemClock), .pllInputClock(pllInputClock),
  .pllOutputClock(pllOutputClock), .pllPowerDown(pllPowerDown),
  .pllCounterClear(pllCounterClear), .pllMultiplier(pllMultiplier),
  .pllInitWord(pllInitWord));

//--- tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic inputSelectPin = 1'b0;
  logic rtcClock = 1'b0;
  logic externalClockInput = 1'b0;
  logic pllCoreClock = 1'b0;
  scm_pkg::scm_wb_req_t wbReq = '0;
  scm_pkg::scm_wb_rsp_t wbRsp;
  logic systemClock, pllInputClock, pllOutputClock;
  logic pllPowerDown, pllCounterClear;
  logic [12:0] pllMultiplier;
  logic [15:0] pllInitWord;
  logic [31:0] rd;
  int n_fail = 0;
  int checked = 0;
  int tick = 0;
  int p;
  always #20 mclk = ~mclk;
  // Sources sped up: rtc period 6, external 4, core 2
  always @(posedge mclk) begin
    tick <= tick + 1;
    pllCoreClock <= ~pllCoreClock;
    if (tick % 2 == 0) externalClockInput <= ~externalClockInput;
    if (tick % 3 == 0) rtcClock <= ~rtcClock;
  end
  scm_clock_mode_ctrl dut (.mclk(mclk), .rst_n(rst_n), .wbReq(wbReq),
    .wbRsp(wbRsp), .inputSelectPin(inputSelectPin), .rtcClock(rtcClock),
    .externalClockInput(externalClockInput), .pllCoreClock(pllCoreClock),
    .systemClock(systemClock), .pllInputClock(pllInputClock),
    .pllOutputClock(pllOutputClock), .pllPowerDown(pllPowerDown),
    .pllCounterClear(pllCounterClear), .pllMultiplier(pllMultiplier),
    .pllInitWord(pllInitWord));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wbXfer(input logic we, input logic [15:0] adr,
      input logic [15:0] dat, output logic [31:0] data);
    @(posedge mclk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3,
      datW: {16'h0000, dat}};
    do begin
      @(posedge mclk);
    end while (wbRsp.ack !== 1'b1);
    data = wbRsp.datR;
    wbReq <= '0;
  endtask : wbXfer
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    wbXfer(1'b1, a, d, rd);
    repeat (50) @(posedge mclk);
  endtask : wr
  function automatic logic pick(input int which);
    case (which)
      0: pick = systemClock;
      1: pick = pllInputClock;
      default: pick = pllOutputClock;
    endcase
  endfunction : pick
  // Cycles between two rising edges
  task automatic measure(input int which, output int per);
    int edges;
    logic prev;
    edges = 0;
    per = 0;
    prev = pick(which);
    while (edges < 2 && per < 400) begin
      @(posedge mclk);
      per++;
      if (pick(which) === 1'b1 && prev !== 1'b1) begin
        edges++;
        if (edges == 1) per = 0;
      end
      prev = pick(which);
    end
  endtask : measure
  task automatic doReset(input logic pin);
    rst_n <= 1'b0;
    inputSelectPin <= pin;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : doReset
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end
  initial begin
    doReset(1'b0);
    wbXfer(1'b0, scm_pkg::ADR_PLL_CTRL_ONE, 16'h0000, rd);
    check(rd, {16'h0000, scm_pkg::RST_PLL_CTRL_ONE});
    check(pllPowerDown, 1'b1);
    wbXfer(1'b0, scm_pkg::ADR_CLK_CFG_TWO, 16'h0000, rd);
    check(rd, 32'h0000_0000);
    wbXfer(1'b0, 16'h7090, 16'h0000, rd);
    check(rd, 32'h0000_0000);
    measure(0, p);
    check(p, 6);
    wr(scm_pkg::ADR_CLK_CFG_TWO, 16'h0000);
    wr(scm_pkg::ADR_PLL_CTRL_ONE, 16'h1005);
    wr(scm_pkg::ADR_PLL_CTRL_TWO, 16'h8000);
    wr(scm_pkg::ADR_PLL_CTRL_FOUR, 16'h0203);
    wr(scm_pkg::ADR_PLL_CTRL_THREE, 16'h0806);
    wr(scm_pkg::ADR_PLL_CTRL_ONE, 16'h8005);
    check(pllInitWord, 16'h0806);
    check(pllMultiplier, 13'h0009);
    check({pllPowerDown, pllCounterClear}, 2'h1);
    measure(1, p);
    check(p, 6);
    measure(2, p);
    check(p, 8);
    wr(scm_pkg::ADR_PLL_CTRL_FOUR, 16'h0003);
    measure(2, p);
    check(p, 2);
    wr(scm_pkg::ADR_PLL_CTRL_TWO, 16'h8000);
    measure(1, p);
    check(p, 6);
    wr(scm_pkg::ADR_PLL_CTRL_FOUR, 16'h0203);
    repeat (200) @(posedge mclk);
    wr(scm_pkg::ADR_CLK_CFG_TWO, 16'h0001);
    measure(0, p);
    check(p, 8);
    wbXfer(1'b0, scm_pkg::ADR_CLK_CFG_TWO, 16'h0000, rd);
    check(rd, 32'h0000_0001);
    wr(scm_pkg::ADR_CLK_CFG_TWO, 16'h0000);
    measure(0, p);
    check(p, 6);
    wr(scm_pkg::ADR_PLL_CTRL_ONE, 16'h9005);
    check({pllPowerDown, pllOutputClock}, 2'h2);
    doReset(1'b1);
    wbXfer(1'b0, scm_pkg::ADR_CLK_CFG_TWO, 16'h0000, rd);
    check(rd, 32'h0000_0008);
    repeat (50) @(posedge mclk);
    measure(0, p);
    check(p, 4);
    wr(scm_pkg::ADR_PLL_CTRL_ONE, 16'h1005);
    wr(scm_pkg::ADR_PLL_CTRL_TWO, 16'h7001);
    wbXfer(1'b0, scm_pkg::ADR_PLL_CTRL_TWO, 16'h0000, rd);
    check(rd, 32'h0000_0001);
    wr(scm_pkg::ADR_PLL_CTRL_THREE, 16'h0806);
    wr(scm_pkg::ADR_PLL_CTRL_ONE, 16'h8005);
    measure(1, p);
    check(p, 20);
    print_verdict();
  end
endmodule : tb_top
